// *** inc/cfgd_consts.svh ***
/*
  Constants of the configuration byte decoder: APB offsets, bit positions,
  reset values and boot addresses. Assumes inclusion by its bare name.
*/
`ifndef CFGD_CONSTS_SVH
`define CFGD_CONSTS_SVH

`define CFGD_OFS_ADDR 12'h000
`define CFGD_OFS_DATA 12'h004
`define CFGD_OFS_CMD 12'h008
`define CFGD_OFS_STATUS 12'h00c

`define CFGD_CFG_ADDR 16'hffff
`define CFGD_APP_BASE 16'h0000
`define CFGD_LOADER_BASE 16'h3800
`define CFGD_ERASED 8'hff

`define CFGD_BIT_LOCK 0
`define CFGD_BIT_INHIBIT 1
`define CFGD_BIT_BOOT 2
`define CFGD_BIT_NSR 3
`define CFGD_BIT_CYCLE 5
`define CFGD_BIT_XTAL 7

`define CFGD_CMD_ERASE_ALL 0
`define CFGD_ST_MODE 8
`define CFGD_ST_LOCKED 9
`define CFGD_ST_LOADED 10

`endif

// *** inc/cfgd_pkg.sv ***
/*
  Types of the configuration byte decoder.
  Assumes nothing of its surroundings.
*/
package cfgd_pkg;
  typedef enum logic [1:0]
  {
    CFGD_LOAD = 2'b01,
    CFGD_RUN = 2'b10
  } cfgd_state_t;
endpackage

// *** logic/cfgd_top.sv ***
/*
  Configuration byte decoder: holds the nonvolatile configuration byte,
  lets a programmer reach it over APB only in programming mode, latches it
  after reset and drives the decoded settings to the core.
  Assumes prog_mode_pin is asynchronous and the core supplies code-table
  read requests on pclk.
  // Contract
  // - With the inhibit bit 0, a code-table read run from external memory never selects internal code.
  // - A code-table read run from internal memory may always reach internal and external code.
  // - With the inhibit bit 1, code-table reads are not restricted at all.
  // - After reset the core boots from the application flash when the boot bit is 1, else from 0x3800.
  // - Noise reduction is disabled when its bit is 1 and enabled when it is 0.
  // - Cycle bit 1 gives twelve clocks per instruction cycle, 0 gives six.
  // - Once the lock bit is 0, flash and configuration byte accesses are refused.
  // - Programming only clears bits; only erase-all sets them back to 1.
  // - The configuration byte is reached only in programming mode at address 0FFFFh.
*/
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "cfgd_consts.svh"

module cfgd_top
  import cfgd_pkg::*;
#(
  parameter logic [15:0] INT_CODE_TOP = 16'h3fff
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic prog_mode_pin,
  input wire logic code_table_read,
  input wire logic ctr_exec_external,
  input wire logic [15:0] ctr_addr,
  output logic ctr_select_internal,
  output logic cfg_valid,
  output logic [15:0] boot_vector,
  output logic boot_from_loader,
  output logic noise_reduction_disable,
  output logic twelve_clock_cycle_mode,
  output logic six_clock_cycle_mode,
  output logic xtal_high_speed
);

  cfgd_state_t state_q;
  // The fuse cell starts erased and is not touched by reset
  logic [7:0] nv_q = `CFGD_ERASED;
  logic [7:0] live_q;
  logic [15:0] addr_q;
  logic pm_s1_q, pm_s2_q, pm_s3_q, pm_q;
  logic acc, wr, rd, hit_data, locked, data_ok, erase;
  logic [31:0] rdata_d;
  logic err_d;

  // Programming-mode pin: a change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pm_s1_q <= 1'b0;
      pm_s2_q <= 1'b0;
      pm_s3_q <= 1'b0;
      pm_q <= 1'b0;
    end
    else
    begin
      pm_s1_q <= prog_mode_pin;
      pm_s2_q <= pm_s1_q;
      pm_s3_q <= pm_s2_q;
      if (pm_s2_q == pm_s3_q)
        pm_q <= pm_s3_q;
    end
  end

  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign hit_data = (paddr == `CFGD_OFS_DATA);
  assign locked = ~nv_q[`CFGD_BIT_LOCK];
  // Refused outside programming mode or once locked
  assign data_ok = pm_q & ~locked;
  assign erase = wr & (paddr == `CFGD_OFS_CMD) & pm_q & pwdata[`CFGD_CMD_ERASE_ALL];
  assign pready = 1'b1;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      addr_q <= 16'h0000;
    else if (wr && paddr == `CFGD_OFS_ADDR)
      addr_q <= pwdata[15:0];
  end

  // Model of the fuse cell: it keeps its contents through reset, so only erase-all sets bits;
  // erase-all works even when locked, else a locked part is dead
  always_ff @(posedge pclk)
  begin
    if (erase)
      nv_q <= `CFGD_ERASED;
    else if (wr && hit_data && data_ok && addr_q == `CFGD_CFG_ADDR)
      nv_q <= nv_q & pwdata[7:0];
  end

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    err_d = 1'b0;
    unique case (paddr)
      `CFGD_OFS_ADDR: rdata_d = {16'h0000, addr_q};
      `CFGD_OFS_DATA:
      begin
        err_d = ~data_ok;
        if (data_ok && addr_q == `CFGD_CFG_ADDR)
          rdata_d = {24'h000000, nv_q};
      end
      `CFGD_OFS_CMD: err_d = pwrite & ~pm_q;
      `CFGD_OFS_STATUS:
      begin
        rdata_d[7:0] = live_q;
        rdata_d[`CFGD_ST_MODE] = pm_q;
        rdata_d[`CFGD_ST_LOCKED] = locked;
        rdata_d[`CFGD_ST_LOADED] = cfg_valid;
      end
      default: err_d = 1'b1;
    endcase
  end

  assign prdata = rd ? rdata_d : 32'h0000_0000;
  assign pslverr = acc & err_d;

  // Settings are captured once after reset; later programming waits for the next reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= CFGD_LOAD;
      live_q <= `CFGD_ERASED;
    end
    else
    begin
      unique case (state_q)
        CFGD_LOAD:
        begin
          live_q <= nv_q;
          state_q <= CFGD_RUN;
        end
        CFGD_RUN: state_q <= CFGD_RUN;
        default: state_q <= CFGD_LOAD;
      endcase
    end
  end

  assign cfg_valid = (state_q == CFGD_RUN);
  assign boot_from_loader = ~live_q[`CFGD_BIT_BOOT];
  assign boot_vector = live_q[`CFGD_BIT_BOOT] ? `CFGD_APP_BASE : `CFGD_LOADER_BASE;
  assign noise_reduction_disable = live_q[`CFGD_BIT_NSR];
  assign twelve_clock_cycle_mode = live_q[`CFGD_BIT_CYCLE];
  assign six_clock_cycle_mode = ~live_q[`CFGD_BIT_CYCLE];
  assign xtal_high_speed = live_q[`CFGD_BIT_XTAL];

  // Internal code is selected for in-range addresses unless an external fetch is inhibited
  assign ctr_select_internal = code_table_read & (ctr_addr <= INT_CODE_TOP)
    & (~ctr_exec_external | live_q[`CFGD_BIT_INHIBIT]);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_inhibit;
    code_table_read && ctr_exec_external && !live_q[`CFGD_BIT_INHIBIT] |-> !ctr_select_internal;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("external code-table read reached internal code");

  property p_internal_exec;
    code_table_read && !ctr_exec_external && ctr_addr <= INT_CODE_TOP |-> ctr_select_internal;
  endproperty
  a_internal_exec: assert property (p_internal_exec) else $error("internal code-table read refused");

  property p_no_restrict;
    code_table_read && live_q[`CFGD_BIT_INHIBIT] |-> ctr_select_internal == (ctr_addr <= INT_CODE_TOP);
  endproperty
  a_no_restrict: assert property (p_no_restrict) else $error("restriction with inhibit bit at one");

  property p_boot;
    cfg_valid |-> boot_vector == (live_q[`CFGD_BIT_BOOT] ? 16'h0000 : 16'h3800) && boot_from_loader == !live_q[2];
  endproperty
  a_boot: assert property (p_boot) else $error("boot vector does not follow boot bit");

  property p_nsr;
    cfg_valid |-> noise_reduction_disable == live_q[3];
  endproperty
  a_nsr: assert property (p_nsr) else $error("noise reduction setting wrong");

  property p_cycle;
    cfg_valid |-> twelve_clock_cycle_mode == live_q[5] && six_clock_cycle_mode == !live_q[5];
  endproperty
  a_cycle: assert property (p_cycle) else $error("cycle mode wrong");

  property p_lock;
    acc && hit_data && !nv_q[0] |-> pslverr && prdata == 32'h0;
  endproperty
  a_lock: assert property (p_lock) else $error("locked access not refused");

  property p_one_way;
    !$past(erase) |-> (nv_q & ~$past(nv_q)) == 8'h00;
  endproperty
  a_one_way: assert property (p_one_way) else $error("bit set without erase");

  property p_normal_mode;
    acc && hit_data && !pm_q |=> $stable(nv_q);
  endproperty
  a_normal_mode: assert property (p_normal_mode) else $error("byte changed outside programming mode");

  property p_stable;
    cfg_valid ##1 cfg_valid |-> $stable(live_q) && live_q == $past(live_q, 1);
  endproperty
  a_stable: assert property (p_stable) else $error("settings changed while running");

  property p_load;
    $rose(cfg_valid) |-> live_q == $past(nv_q);
  endproperty
  a_load: assert property (p_load) else $error("latched byte differs from stored byte");

  c_program: cover property (wr && hit_data && data_ok && addr_q == 16'hffff);
  c_erase: cover property (erase);
  c_blocked: cover property (code_table_read && ctr_exec_external && !ctr_select_internal);
  c_lock_refuse: cover property (acc && hit_data && pm_q && locked);

endmodule

// *** tb/cfgd_prog_model.sv ***
/*
  Programmer model: APB master and programming-mode pin.
  Assumes apb and mode are called just after a rising pclk edge.
*/
`timescale 1ns/100ps
module cfgd_prog_model
#(
  parameter int CLK_MHZ = 125
)
(
  input wire logic pclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [11:0] paddr = 12'h000,
  output logic [31:0] pwdata = 32'h0,
  output logic prog_mode_pin = 1'b0
);
  int tmo = 0;
  function automatic logic [7:0] fix(input logic [7:0] v);
    fix = {CLK_MHZ > 24, v[6:0]};
  endfunction
  // The synchroniser needs a few edges before data access opens
  task automatic mode(input logic m);
    prog_mode_pin <= m;
    repeat (8) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16) tmo++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines must not keep looking valid
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// *** tb/tb_top.sv ***
/*
  Bench for the configuration byte decoder, random and corner stimulus.
  Assumes the programmer model drives APB and the mode pin.
*/
`timescale 1ns/100ps
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, prog_mode_pin, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic code_table_read = 1'b0;
  logic ctr_exec_external = 1'b0;
  logic [15:0] ctr_addr = 16'h0000;
  logic ctr_select_internal, cfg_valid, boot_from_loader, noise_reduction_disable;
  logic twelve_clock_cycle_mode, six_clock_cycle_mode, xtal_high_speed;
  logic [15:0] boot_vector;
  logic [7:0] v, w;
  int errors = 0;
  int checks_done = 0;
  always #4 pclk = ~pclk;
  cfgd_top cfgd_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .prog_mode_pin, .code_table_read, .ctr_exec_external, .ctr_addr, .ctr_select_internal,
    .cfg_valid, .boot_vector, .boot_from_loader, .noise_reduction_disable, .twelve_clock_cycle_mode,
    .six_clock_cycle_mode, .xtal_high_speed);
  cfgd_prog_model cfgd_prog_model_inst (.pclk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prog_mode_pin);
  function automatic logic f_sel(logic r, logic x, logic [15:0] a, logic inh);
    f_sel = r & (a <= 16'h3fff) & (~x | inh);
  endfunction
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e)
    begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    cfgd_prog_model_inst.apb(wr, a, d, rd, er);
    if (cfgd_prog_model_inst.tmo > 0)
    begin
      errors++;
      close_out();
    end
  endtask
  task automatic dec(input logic [7:0] b);
    chk("boot_vector", b[2] ? 32'h0 : 32'h3800, boot_vector);
    chk("loader", !b[2], boot_from_loader);
    chk("nsr_dis", b[3], noise_reduction_disable);
    chk("twelve", b[5], twelve_clock_cycle_mode);
    chk("six", !b[5], six_clock_cycle_mode);
    chk("xtal", b[7], xtal_high_speed);
    repeat (8)
    begin
      @(posedge pclk);
      code_table_read <= 1'($urandom);
      ctr_exec_external <= 1'($urandom);
      ctr_addr <= 16'($urandom) & 16'h7fff;
      @(negedge pclk);
      chk("ctr_sel", f_sel(code_table_read, ctr_exec_external, ctr_addr, b[1]), ctr_select_internal);
    end
  endtask
  initial
  begin
    void'($urandom(32'h126f730d));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // The byte is latched at the first edge after release
    @(posedge pclk);
    @(negedge pclk);
    chk("cfg_valid", 1'b1, cfg_valid);
    dec(8'hff);
    acc(1'b1, 12'h004, 32'h0);
    chk("data_refused", 1'b1, er);
    acc(1'b0, 12'h010, 32'h0);
    chk("unmapped", 1'b1, er);
    acc(1'b1, 12'h008, 32'h1);
    chk("cmd_refused", 1'b1, er);
    $display("test defaults ends");
    cfgd_prog_model_inst.mode(1'b1);
    acc(1'b1, 12'h000, 32'hffff);
    v = cfgd_prog_model_inst.fix(8'($urandom) | 8'h01);
    acc(1'b1, 12'h004, {24'h0, v});
    // Inhibit and boot bits forced to 0 so the restricted and loader paths run
    w = (8'($urandom) | 8'h81) & 8'hf9;
    acc(1'b1, 12'h004, {24'h0, w});
    v = v & w;
    acc(1'b0, 12'h004, 32'h0);
    chk("data_and", {24'h0, v}, rd);
    dec(8'hff);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    @(negedge pclk);
    chk("cfg_valid2", 1'b1, cfg_valid);
    dec(v);
    acc(1'b0, 12'h00c, 32'h0);
    chk("status", {21'h0, 3'b101, v}, rd);
    $display("test program ends");
    cfgd_prog_model_inst.mode(1'b1);
    acc(1'b1, 12'h000, 32'hffff);
    acc(1'b1, 12'h004, 32'hfe);
    acc(1'b0, 12'h004, 32'h0);
    chk("locked", 1'b1, er);
    acc(1'b1, 12'h008, 32'h1);
    acc(1'b0, 12'h004, 32'h0);
    chk("erased", 32'hff, rd);
    $display("test lock ends");
    close_out();
  end
  initial
  begin
    #200000;
    errors++;
    close_out();
  end
endmodule
